// file: rtl/rsc_pkg.sv
// Constants, register map and state codes of the reset source controller.
`default_nettype none
package rsc_pkg;
  // ==========================================================================
  // Clock and timing
  localparam int CLK_MHZ = 25;
  localparam int INIT_BASE_NS = 200;
  localparam int STARTUP_STEP_NS = 1000;
  localparam int CRC_SCAN_NS = 20000;
  localparam int INIT_BASE_CYC = (INIT_BASE_NS * CLK_MHZ + 999) / 1000;
  localparam int STARTUP_STEP_CYC = (STARTUP_STEP_NS * CLK_MHZ + 999) / 1000;
  localparam int CRC_SCAN_CYC = (CRC_SCAN_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 12;
  // ==========================================================================
  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IDX_CAUSE = 8'h00;
  localparam logic [7:0] IDX_SOFTWARE_RESET = 8'h01;
  localparam logic [7:0] IDX_KEY = 8'h02;
  localparam logic [7:0] IDX_STATUS = 8'h03;
  localparam int ADDR_W = 4;
  // ==========================================================================
  // Field positions
  localparam int POS_PWRON = 0;
  localparam int POS_BROWN = 1;
  localparam int POS_PIN = 2;
  localparam int POS_WDOG = 3;
  localparam int POS_SOFT = 4;
  localparam int POS_DEBUG = 5;
  localparam int POS_SOFT_EN = 0;
  localparam int NSRC = 6;
  localparam logic [5:0] PWR_SRC_MASK = 6'h03;
  // ==========================================================================
  // Reset values and protection
  localparam logic [5:0] CAUSE_RST = 6'h00;
  localparam logic [2:0] SUT_RST = 3'h0;
  localparam logic [4:0] SYNC_RST = 5'h04;
  localparam logic [2:0] UNLOCK_WRITES = 3'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // ==========================================================================
  // Sequencer states
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_SRC = 2'b01,
    ST_INIT = 2'b10
  } rsc_state_e;
endpackage
`default_nettype wire

// file: rtl/rsc_reset_controller.sv
// Reset source controller: combines reset requests, sequences reset and records its cause.
// Overview of operation
// - Six sources, power and user groups, each forces a device reset.
// - Controller always on; fuse-enabled sources request nothing until enabled.
// - After reset ends, the causing source is readable in the cause register.
// - Power-on holds reset while active and through the initialization sequence.
// - Brown-out detection below trigger level issues a reset.
// - When fuse-enabled, low reset pin holds reset until pin returns high.
// - Watchdog time-out issues a reset.
// - Writing one to soft reset enable starts reset until sequence completes.
// - Power resets also reset the debug interface; other resets spare it.
// - Every reset reloads fuse-loaded registers.
// - Reset has a source phase, then initialization after all sources release.
// - Power-caused resets lengthen initialization by the fuse start-up time.
// - Enabled start-up CRC scan lengthens initialization by its duration.
// - Controller works in active and every sleep mode.
// - Soft reset write needs key write first, then write within four writes; reads do not count.
// - Protected write without unlock leaves the register unchanged.
// - Cause bits: 5 debug, 4 soft, 3 watchdog, 2 pin, 1 brown-out, 0 power-on.
// - Writing one clears a cause flag; zero leaves it.
// - Power-on reset clears every cause flag except the power-on flag.
// - After power-on only its flag is set until a full boot runs.
// - Soft reset enable bit always reads zero.
//
// Chosen here: the AXI4-Lite slave port.
`default_nettype none
module rsc_reset_controller #(
  parameter logic [7:0] KEY_VALUE = 8'ha5
) (
  // Clock, reset and clock enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite write address and data
  input wire logic [rsc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [rsc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Reset sources from pins and other domains
  input wire logic poweron_req,
  input wire logic brownout_req,
  input wire logic reset_pin_n,
  input wire logic watchdog_req,
  input wire logic debug_req,
  // Fuse values
  input wire logic fuse_reset_pin_en,
  input wire logic fuse_brownout_en,
  input wire logic [2:0] fuse_startup_time,
  input wire logic fuse_crc_scan_en,
  // Reset outputs
  output logic sys_reset_n,
  output logic debug_reset_n,
  output logic fuse_reload
);
  import rsc_pkg::*;

  // ==========================================================================
  // Input synchronisers
  logic [4:0] sync_a;
  logic [4:0] sync_b;
  logic [4:0] raw_in;
  assign raw_in = {debug_req, watchdog_req, reset_pin_n, brownout_req, poweron_req};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_a <= SYNC_RST;
      sync_b <= SYNC_RST;
    end else if (ce) begin
      sync_a <= raw_in;
      sync_b <= sync_a;
    end
  end
  // ==========================================================================
  // Fuse shadow registers
  logic pin_en;
  logic bod_en;
  logic [2:0] startup_time_field;
  logic crc_en;
  logic next_pin_en;
  logic next_bod_en;
  logic [2:0] next_sut;
  logic next_crc_en;
  // ==========================================================================
  // Source combination
  logic sw_req;
  logic [NSRC-1:0] req;
  logic any_req;
  always_comb begin
    req = '0;
    req[POS_PWRON] = sync_b[0];
    req[POS_BROWN] = sync_b[1] & bod_en;
    req[POS_PIN] = ~sync_b[2] & pin_en;
    req[POS_WDOG] = sync_b[3];
    req[POS_SOFT] = sw_req;
    req[POS_DEBUG] = sync_b[4];
    any_req = |req;
  end
  // ==========================================================================
  // Sequencer
  rsc_state_e state;
  rsc_state_e next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [NSRC-1:0] pend;
  logic [NSRC-1:0] next_pend;
  logic [NSRC-1:0] cause;
  logic [NSRC-1:0] next_cause;
  logic next_sys_reset_n;
  logic next_debug_reset_n;
  logic next_fuse_reload;
  logic [NSRC-1:0] cause_clr;
  logic [CNT_W-1:0] init_len;
  always_comb begin
    init_len = CNT_W'(INIT_BASE_CYC);
    if ((pend & PWR_SRC_MASK) != '0) begin
      init_len = init_len + CNT_W'(startup_time_field * STARTUP_STEP_CYC);
    end
    if (crc_en) begin
      init_len = init_len + CNT_W'(CRC_SCAN_CYC);
    end
  end
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_pend = pend;
    next_fuse_reload = 1'b0;
    next_pin_en = pin_en;
    next_bod_en = bod_en;
    next_sut = startup_time_field;
    next_crc_en = crc_en;
    next_cause = cause & ~cause_clr;
    case (state)
      ST_RUN: begin
        if (any_req) begin
          next_state = ST_SRC;
          next_pend = req;
        end
      end
      ST_SRC: begin
        next_pend = pend | req;
        if (!any_req) begin
          next_state = ST_INIT;
          next_cnt = init_len;
          next_fuse_reload = 1'b1;
          next_pin_en = fuse_reset_pin_en;
          next_bod_en = fuse_brownout_en;
          next_sut = fuse_startup_time;
          next_crc_en = fuse_crc_scan_en;
        end
      end
      ST_INIT: begin
        if (any_req) begin
          next_state = ST_SRC;
          next_pend = pend | req;
        end else if (cnt == '0) begin
          next_state = ST_RUN;
          if (pend[POS_PWRON]) begin
            next_cause = '0;
            next_cause[POS_PWRON] = 1'b1;
          end else begin
            next_cause = next_cause | pend;
          end
          next_pend = '0;
        end else begin
          next_cnt = cnt - CNT_W'(1);
        end
      end
      default: begin
        next_state = ST_SRC;
      end
    endcase
    next_sys_reset_n = (next_state == ST_RUN);
    next_debug_reset_n = !((next_state != ST_RUN) && ((next_pend & PWR_SRC_MASK) != '0));
  end
  // No state here depends on the sleep mode.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_SRC;
      cnt <= '0;
      pend <= '0;
      cause <= CAUSE_RST;
      sys_reset_n <= 1'b0;
      debug_reset_n <= 1'b0;
      fuse_reload <= 1'b0;
      pin_en <= 1'b0;
      bod_en <= 1'b0;
      startup_time_field <= SUT_RST;
      crc_en <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      cnt <= next_cnt;
      pend <= next_pend;
      cause <= next_cause;
      sys_reset_n <= next_sys_reset_n;
      debug_reset_n <= next_debug_reset_n;
      fuse_reload <= next_fuse_reload;
      pin_en <= next_pin_en;
      bod_en <= next_bod_en;
      startup_time_field <= next_sut;
      crc_en <= next_crc_en;
    end
  end
  // ==========================================================================
  // AXI4-Lite slave
  logic aw_got;
  logic w_got;
  logic [ADDR_W-3:0] aw_idx;
  logic [7:0] w_byte;
  logic w_lane0;
  logic [1:0] bresp;
  logic bvalid;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic [2:0] unlock;
  logic next_aw_got;
  logic next_w_got;
  logic [ADDR_W-3:0] next_aw_idx;
  logic [7:0] next_w_byte;
  logic next_w_lane0;
  logic [1:0] next_bresp;
  logic next_bvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic next_rvalid;
  logic [2:0] next_unlock;
  logic next_sw_req;
  logic wr_fire;
  logic [7:0] wr_idx;
  logic [7:0] rd_idx;
  assign s_axi_awready = ce & ~aw_got & ~bvalid;
  assign s_axi_wready = ce & ~w_got & ~bvalid;
  assign s_axi_arready = ce & ~rvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_bvalid = bvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;
  assign s_axi_rvalid = rvalid;
  assign wr_fire = aw_got & w_got & ~bvalid;
  assign wr_idx = {{(10 - ADDR_W){1'b0}}, aw_idx};
  assign rd_idx = {{(10 - ADDR_W){1'b0}}, s_axi_araddr[ADDR_W-1:2]};
  always_comb begin
    next_aw_got = aw_got;
    next_w_got = w_got;
    next_aw_idx = aw_idx;
    next_w_byte = w_byte;
    next_w_lane0 = w_lane0;
    next_bresp = bresp;
    next_bvalid = bvalid;
    next_unlock = unlock;
    next_sw_req = 1'b0;
    cause_clr = '0;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_got = 1'b1;
      next_aw_idx = s_axi_awaddr[ADDR_W-1:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_got = 1'b1;
      next_w_byte = s_axi_wdata[7:0];
      next_w_lane0 = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (wr_fire) begin
      next_aw_got = 1'b0;
      next_w_got = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      if (unlock != '0) begin
        next_unlock = unlock - 3'h1;
      end
      case (wr_idx)
        IDX_CAUSE: begin
          if (w_lane0) begin
            cause_clr = w_byte[NSRC-1:0];
          end
        end
        IDX_SOFTWARE_RESET: begin
          if (w_lane0 && unlock != '0) begin
            next_sw_req = w_byte[POS_SOFT_EN];
            next_unlock = '0;
          end
        end
        IDX_KEY: begin
          if (w_lane0 && w_byte == KEY_VALUE) begin
            next_unlock = UNLOCK_WRITES;
          end
        end
        IDX_STATUS: begin
          next_bresp = RESP_OKAY;
        end
        default: begin
          next_bresp = RESP_DECERR;
        end
      endcase
    end
  end
  always_comb begin
    next_rdata = rdata;
    next_rresp = rresp;
    next_rvalid = rvalid;
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      next_rdata = '0;
      case (rd_idx)
        IDX_CAUSE: begin
          next_rdata = {26'h0, cause};
        end
        IDX_SOFTWARE_RESET: begin
          next_rdata = '0;
        end
        IDX_KEY: begin
          next_rdata = {29'h0, unlock};
        end
        IDX_STATUS: begin
          next_rdata = {18'h0, 2'(state), cnt};
        end
        default: begin
          next_rresp = RESP_DECERR;
        end
      endcase
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_idx <= '0;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
      bresp <= RESP_OKAY;
      bvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= RESP_OKAY;
      rvalid <= 1'b0;
      unlock <= 3'h0;
      sw_req <= 1'b0;
    end else if (ce) begin
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      aw_idx <= next_aw_idx;
      w_byte <= next_w_byte;
      w_lane0 <= next_w_lane0;
      bresp <= next_bresp;
      bvalid <= next_bvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      rvalid <= next_rvalid;
      unlock <= next_unlock;
      sw_req <= next_sw_req;
    end
  end
  // ==========================================================================
  // Assertions
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_reset_held: assert property (state != ST_RUN |-> !sys_reset_n)
    else $error("system reset released outside run state");
  chk_enter_src: assert property ((ce && state == ST_RUN && any_req) |=> (state == ST_SRC && !sys_reset_n))
    else $error("request did not enter reset");
  chk_init_after: assert property ((ce && state == ST_SRC && !any_req) |=> (state == ST_INIT && fuse_reload))
    else $error("release did not start initialization");
  chk_src_reenter: assert property ((ce && state == ST_INIT && any_req) |=> state == ST_SRC)
    else $error("request during initialization ignored");
  chk_por_only: assert property ((ce && state == ST_INIT && !any_req && cnt == '0 && pend[POS_PWRON])
    |=> (cause == 6'h01 && sys_reset_n))
    else $error("power-on cause not exclusive");
  chk_debug_domain: assert property (!debug_reset_n |-> !sys_reset_n)
    else $error("debug reset without system reset");
  chk_locked_write: assert property ((ce && wr_fire && wr_idx == IDX_SOFTWARE_RESET && unlock == '0) |=> !sw_req)
    else $error("locked soft reset write took effect");
  chk_sw_start: assert property ((ce && wr_fire && wr_idx == IDX_SOFTWARE_RESET && unlock != '0 && w_lane0 && w_byte[0])
    |=> sw_req)
    else $error("unlocked soft reset write ignored");
  chk_soft_reset_enable_bit_zero: assert property ((ce && s_axi_arvalid && s_axi_arready && rd_idx == IDX_SOFTWARE_RESET)
    |=> (rvalid && rdata == 32'h0))
    else $error("soft reset register read nonzero");
endmodule
`default_nettype wire

// file: verification/rsc_src_model.sv
// Model of the reset sources: supply monitors, reset pin, watchdog and debugger.
`default_nettype none
module rsc_src_model (
  // Clock and source selection from the bench
  input wire logic aclk,
  input wire logic [5:0] src_cmd,
  // Requests into the controller
  output logic poweron_req,
  output logic brownout_req,
  output logic reset_pin_n,
  output logic watchdog_req,
  output logic debug_req
);
  timeunit 1ns;
  timeprecision 1ps;
  import rsc_pkg::*;
  logic [5:0] held = 6'h00;
  // Sources change on a rising clock edge, one cycle after src_cmd, so they are aligned to the clock.
  always @(posedge aclk) begin
    held <= src_cmd;
  end
  assign poweron_req = held[POS_PWRON];
  assign brownout_req = held[POS_BROWN];
  assign reset_pin_n = ~held[POS_PIN];
  assign watchdog_req = held[POS_WDOG];
  assign debug_req = held[POS_DEBUG];
endmodule
`default_nettype wire

// file: verification/rsc_reset_controller_tb.sv
// Self-checking bench of the reset source controller.
`default_nettype none
`define CHK(got, exp, msg) begin comparisons++; if ((got) !== (exp)) begin error_cnt++; \
  $display("MISMATCH t=%0t %s got %0h exp %0h", $time, msg, got, exp); end end
module rsc_reset_controller_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rsc_pkg::*;
  localparam logic [7:0] KEY = 8'ha5;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic poweron_req, brownout_req, reset_pin_n, watchdog_req, debug_req;
  logic [5:0] src_cmd = 6'h00;
  logic pin_en = 1'b1, bod_en = 1'b1, crc_en = 1'b0;
  logic [2:0] startup_time_field = 3'h3;
  logic sys_reset_n, debug_reset_n, fuse_reload;
  int error_cnt = 0;
  int comparisons = 0;
  int fr_cnt = 0;
  int srcs[5] = '{POS_PIN, POS_WDOG, POS_DEBUG, POS_BROWN, POS_PWRON};

  rsc_reset_controller #(.KEY_VALUE(KEY)) i_rsc_reset_controller (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .poweron_req(poweron_req), .brownout_req(brownout_req),
    .reset_pin_n(reset_pin_n), .watchdog_req(watchdog_req), .debug_req(debug_req),
    .fuse_reset_pin_en(pin_en), .fuse_brownout_en(bod_en), .fuse_startup_time(startup_time_field),
    .fuse_crc_scan_en(crc_en), .sys_reset_n(sys_reset_n), .debug_reset_n(debug_reset_n),
    .fuse_reload(fuse_reload));

  rsc_src_model i_rsc_src_model (.aclk(aclk), .src_cmd(src_cmd), .poweron_req(poweron_req),
    .brownout_req(brownout_req), .reset_pin_n(reset_pin_n), .watchdog_req(watchdog_req),
    .debug_req(debug_req));

  initial begin
    forever #20 aclk = ~aclk;
  end

  // ==========================================================================
  // Bus tasks: ready is looked at on the falling edge, so it is the value sampled at the next rising edge.
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      aw = aw & ~awready;
      w = w & ~wready;
      @(posedge aclk);
      awvalid <= aw;
      wvalid <= w;
    end while (aw | w);
    while (bvalid !== 1'b1) @(negedge aclk);
    `CHK(bresp, RESP_OKAY, "write response")
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(negedge aclk);
    d = rdata;
    `CHK(rresp, RESP_OKAY, "read response")
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  // ==========================================================================
  // Reset observation tasks
  task automatic wait_rel(output int n);
    n = 0;
    fr_cnt = 0;
    do begin
      @(negedge aclk);
      n++;
      if (fuse_reload === 1'b1) fr_cnt++;
    end while (sys_reset_n !== 1'b1 && n < 3000);
  endtask

  task automatic wait_low(input int lim, output logic got);
    got = 1'b0;
    for (int i = 0; i < lim && !got; i++) begin
      @(negedge aclk);
      got = (sys_reset_n === 1'b0);
    end
  endtask

  task automatic pulse(input int pos, output logic lo, output logic dbg, output int n);
    @(posedge aclk);
    src_cmd <= 6'(1 << pos);
    repeat ($urandom_range(20, 6)) @(posedge aclk);
    @(negedge aclk);
    lo = sys_reset_n;
    dbg = debug_reset_n;
    @(posedge aclk);
    src_cmd <= 6'h00;
    wait_rel(n);
  endtask

  // Expected length of the initialization count for one source and the fuse values of the last reload.
  function automatic int exp_init(input int pos, input logic [2:0] st, input logic scan);
    int len;
    len = INIT_BASE_CYC + (scan ? CRC_SCAN_CYC : 0);
    if (pos inside {POS_BROWN, POS_PWRON}) len += int'(st) * STARTUP_STEP_CYC;
    return len;
  endfunction

  // Expected cause flags after a reset from one source.
  function automatic logic [5:0] exp_cause(input int pos);
    return (pos == POS_PWRON) ? 6'h01 : 6'(1 << pos);
  endfunction

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge aclk);
    error_cnt++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    complete_run();
  end

  // ==========================================================================
  // Tests
  initial begin
    logic [31:0] d;
    logic got, dbg;
    int n, e;
    void'($urandom(32'hca0b306f));
    startup_time_field <= 3'($urandom_range(7, 1));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    wait_rel(n);
    axi_rd(4'h0, d);
    `CHK(d[5:0], 6'h00, "cause after block reset")
    axi_rd(4'h4, d);
    `CHK(d, 32'h0, "trigger readback")
    axi_rd(4'hc, d);
    `CHK(d[13:12], 2'(ST_RUN), "run state after block reset")
    $display("test idle done");
    // Key then trigger as 1st to 5th write, then a wrong key, then no key.
    for (int i = 0; i < 7; i++) begin
      if (i < 6) axi_wr(4'h8, {24'h0, (i == 5) ? ~KEY : KEY});
      for (int j = 0; j < i && i < 5; j++) axi_wr(4'h0, 32'h0);
      axi_rd(4'h8, d);
      `CHK(d, (i < 5) ? 32'(UNLOCK_WRITES - i) : 32'h0, "unlock count")
      axi_wr(4'h4, 32'h1);
      wait_low(12, got);
      `CHK(got, i < 4, "soft reset taken")
      if (got) begin
        wait_rel(n);
        `CHK(fr_cnt, 1, "fuse reload pulses")
        axi_rd(4'h0, d);
        `CHK(d[5:0], 6'h10, "soft cause")
        axi_wr(4'h0, $urandom & ~32'h10);
        axi_rd(4'h0, d);
        `CHK(d[5:0], 6'h10, "zero write keeps flag")
        axi_wr(4'h0, 32'h10);
        axi_rd(4'h0, d);
        `CHK(d[5:0], 6'h00, "one write clears flag")
      end
      $display("test protect %0d done", i);
    end
    // Power-on comes last and finds the brown-out flag still set.
    foreach (srcs[s]) begin
      pulse(srcs[s], got, dbg, n);
      `CHK(got, 1'b0, "held in reset")
      `CHK(dbg, !(srcs[s] inside {POS_BROWN, POS_PWRON}), "debug reset")
      e = exp_init(srcs[s], startup_time_field, 1'b0);
      `CHK(n >= e && n <= e + 8, 1'b1, "init length")
      axi_rd(4'h0, d);
      `CHK(d[5:0], exp_cause(srcs[s]), "source cause")
      if (srcs[s] != POS_BROWN) axi_wr(4'h0, 32'h3f);
      $display("test source %0d done", srcs[s]);
    end
    @(posedge aclk);
    pin_en <= 1'b0;
    bod_en <= 1'b0;
    crc_en <= 1'b1;
    pulse(POS_WDOG, got, dbg, n);
    pulse(POS_PIN, got, dbg, n);
    `CHK(got, 1'b1, "disabled pin ignored")
    pulse(POS_BROWN, got, dbg, n);
    `CHK(got, 1'b1, "disabled brown-out ignored")
    pulse(POS_WDOG, got, dbg, n);
    e = exp_init(POS_WDOG, startup_time_field, 1'b1);
    `CHK(n >= e && n <= e + 8, 1'b1, "init with scan")
    $display("test fuses done");
    // A request made while the clock enable is low waits; a debug request during initialization restarts it.
    axi_wr(4'h0, 32'h3f);
    @(posedge aclk);
    ce <= 1'b0;
    src_cmd <= 6'(1 << POS_WDOG);
    repeat (8) @(posedge aclk);
    @(negedge aclk);
    `CHK({sys_reset_n, awready, arready}, 3'b100, "frozen while disabled")
    @(posedge aclk);
    ce <= 1'b1;
    wait_low(12, got);
    `CHK(got, 1'b1, "request seen after enable")
    @(posedge aclk);
    src_cmd <= 6'h00;
    repeat (20) @(posedge aclk);
    src_cmd <= 6'(1 << POS_DEBUG);
    repeat (8) @(posedge aclk);
    src_cmd <= 6'h00;
    wait_rel(n);
    `CHK(n >= e && n <= e + 8, 1'b1, "restarted init")
    axi_rd(4'h0, d);
    `CHK(d[5:0], exp_cause(POS_WDOG) | exp_cause(POS_DEBUG), "both causes")
    $display("test restart done");
    complete_run();
  end
endmodule
`default_nettype wire
